// File: hdl/sra_port.sv
// SPI slave giving an external master access to the 8-bit register space
//
// Functional notes
// (RULE_01) Four-wire full duplex only, no three-wire
// (RULE_02) Every command and data item is eight bits
// (RULE_03) Sample on rising clock, clock idles high
// (RULE_04) Only four commands; other codes do nothing (the code decodes three: set pointer, write, read)
// (RULE_05) Shift out pointer byte while shifting in
// (RULE_06) Write is command then data byte
// (RULE_07) Read: master keeps clocking per wanted byte
// (RULE_08) Respond only while chip select is low
// (RULE_09) Pointer increments after read/write, wraps at FFh
// (RULE_10) No timeout on idle clock or select
// (RULE_11) Several commands per chip select frame
// (RULE_12) Two 7Ah bytes reset the serial interface
// (RULE_13) Set pointer loads pointer and fetches register
// (RULE_14) Write: fetch, store, then increment pointer
// (RULE_15) Set-pointer and write return bytes may be invalid
// (RULE_16) Command codes are design parameters
// (RULE_17) Output off and partial byte cleared when deselected
`timescale 1ns/10ps
`default_nettype none
module sra_port
  import sra_pkg::*;
#(
  parameter logic [7:0] CMD_PTR = SRA_CMD_PTR_DEF,
  parameter logic [7:0] CMD_WRITE = SRA_CMD_WRITE_DEF,
  parameter logic [7:0] CMD_READ = SRA_CMD_READ_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial link
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // Register space of the device core
  output sra_reg_req_type reg_req,
  input wire logic [7:0] reg_rdata
);

  sra_pins_type pins_raw;
  sra_pins_type pins_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;

  assign pins_raw = '{sclk: spi_sclk, cs_n: spi_cs_n, mosi: spi_mosi};

  sra_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .pins_i(pins_raw),
    .pins_o(pins_s)
  );

  sra_edge u_sclk_edge (
    .clk(clk),
    .resetn(resetn),
    .level_i(pins_s.sclk),
    .rise_o(sclk_rise),
    .fall_o(sclk_fall)
  );

  sra_edge u_cs_edge (
    .clk(clk),
    .resetn(resetn),
    .level_i(pins_s.cs_n),
    .rise_o(cs_rise),
    .fall_o(cs_fall)
  );

  sra_phase_type phase_q;
  sra_phase_type phase_d;
  logic [2:0] bitcnt_q;
  logic [2:0] bitcnt_d;
  logic [7:0] rx_q;
  logic [7:0] rx_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic prev7a_q;
  logic prev7a_d;
  logic we_q;
  logic we_d;
  logic fetch_q;
  logic fetch_d;
  logic inc_q;
  logic inc_d;
  logic oe_q;
  logic oe_d;
  logic [7:0] byte_w;
  logic byte_done;

  // Byte as it stands after the current rising edge, MSB first
  assign byte_w = {rx_q[6:0], pins_s.mosi};
  assign byte_done = sclk_rise && !pins_s.cs_n && (bitcnt_q == SRA_LAST_BIT);

  always_comb begin
    phase_d = phase_q;
    bitcnt_d = bitcnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    wdata_d = wdata_q;
    prev7a_d = prev7a_q;
    we_d = 1'b0;
    fetch_d = 1'b0;
    inc_d = 1'b0;
    oe_d = oe_q;
    if (inc_q) begin
      ptr_d = sra_inc8(ptr_q); // RULE_09
    end
    if (fetch_q) begin
      tx_d = reg_rdata; // RULE_13
    end
    if (pins_s.cs_n) begin
      // Deselected: drop partial byte, release the output
      oe_d = 1'b0; // RULE_17 RULE_08
      bitcnt_d = SRA_BIT_RST; // RULE_17
      rx_d = SRA_BYTE_RST;
      phase_d = PH_CMD;
    end else if (cs_fall) begin
      // First bit must be on the line before the first falling edge
      oe_d = 1'b1; // RULE_01
      tx_d = reg_rdata; // RULE_05
    end else if (sclk_rise) begin
      // Count only advances on clock edges; no idle limit
      rx_d = byte_w; // RULE_03 RULE_10
      bitcnt_d = bitcnt_q + 3'h1; // RULE_02
      if (byte_done) begin
        tx_d = reg_rdata; // RULE_05 RULE_14
        if ((byte_w == SRA_RESET_CODE) && prev7a_q) begin
          phase_d = PH_CMD; // RULE_12
          prev7a_d = 1'b0;
        end else begin
          prev7a_d = (byte_w == SRA_RESET_CODE); // RULE_12
          case (phase_q)
            PH_CMD: begin
              // Unknown codes fall through untouched
              if (byte_w == CMD_PTR) begin // RULE_16
                phase_d = PH_PTR; // RULE_04
              end else if (byte_w == CMD_WRITE) begin
                phase_d = PH_WRITE; // RULE_04
              end else if (byte_w == CMD_READ) begin
                phase_d = PH_READ; // RULE_04
                inc_d = 1'b1; // RULE_09
              end
            end
            PH_PTR: begin
              ptr_d = byte_w; // RULE_13
              fetch_d = 1'b1; // RULE_13
              phase_d = PH_CMD; // RULE_11
            end
            PH_WRITE: begin
              we_d = 1'b1; // RULE_14
              wdata_d = byte_w;
              inc_d = 1'b1; // RULE_14
              phase_d = PH_CMD; // RULE_11
            end
            PH_READ: begin
              inc_d = 1'b1; // RULE_09
            end
            default: begin
              phase_d = PH_CMD;
            end
          endcase
        end
      end
    end else if (sclk_fall && (bitcnt_q != SRA_BIT_RST)) begin
      // No shift on the fall that presents a fresh byte's first bit
      tx_d = {tx_q[6:0], 1'b1}; // RULE_05
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_q <= PH_CMD;
      bitcnt_q <= SRA_BIT_RST;
      rx_q <= SRA_BYTE_RST;
      tx_q <= SRA_TX_RST;
      ptr_q <= SRA_PTR_RST;
      wdata_q <= SRA_BYTE_RST;
      prev7a_q <= 1'b0;
      we_q <= 1'b0;
      fetch_q <= 1'b0;
      inc_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      bitcnt_q <= bitcnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      wdata_q <= wdata_d;
      prev7a_q <= prev7a_d;
      we_q <= we_d;
      fetch_q <= fetch_d;
      inc_q <= inc_d;
      oe_q <= oe_d;
    end
  end

  // Write strobe uses the pointer before its increment lands
  assign reg_req = '{addr: ptr_q, wdata: wdata_q, we: we_q};
  assign spi_miso = tx_q[7];
  assign spi_miso_oe = oe_q;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence seq_ptr_byte;
    byte_done && (phase_q == PH_PTR);
  endsequence

  sequence seq_write_byte;
    byte_done && (phase_q == PH_WRITE);
  endsequence

  sequence seq_reset_pair;
    byte_done && (byte_w == SRA_RESET_CODE) && prev7a_q;
  endsequence

  // A reset pair ends a read without a further increment
  sequence seq_read_byte;
    byte_done && (phase_q == PH_READ) && !((byte_w == SRA_RESET_CODE) && prev7a_q);
  endsequence

  sequence seq_cmd_byte;
    byte_done && (phase_q == PH_CMD) && !((byte_w == SRA_RESET_CODE) && prev7a_q);
  endsequence

  sequence seq_bit_in;
    sclk_rise && !pins_s.cs_n && !cs_fall;
  endsequence

  sequence seq_link_idle;
    !pins_s.cs_n && !cs_fall && !sclk_rise && !sclk_fall;
  endsequence

  AST_OE_OFF: assert property (pins_s.cs_n |=> !spi_miso_oe) // RULE_17
    else $error("output enabled while deselected");
  AST_RX_CLEAR: assert property (pins_s.cs_n |=> (bitcnt_q == SRA_BIT_RST)) // RULE_17
    else $error("partial byte kept after deselect");
  AST_PTR_LOAD: assert property (seq_ptr_byte |=> (ptr_q == $past(byte_w))) // RULE_13
    else $error("pointer not loaded by set pointer");
  AST_PTR_FETCH: assert property (seq_ptr_byte |=> ##1 (tx_q == $past(reg_rdata))) // RULE_13
    else $error("register not fetched after pointer load");
  AST_WRITE_SEQ: assert property (seq_write_byte |=> // RULE_14
      (reg_req.we && (reg_req.wdata == $past(byte_w)) && (reg_req.addr == $past(ptr_q)))
      ##1 (ptr_q == sra_inc8($past(ptr_q, 2))))
    else $error("write store or increment wrong");
  AST_READ_INC: assert property (seq_read_byte |=> // RULE_09
      ##1 (ptr_q == sra_inc8($past(ptr_q, 2))))
    else $error("pointer not incremented on read");
  AST_WRAP: assert property (inc_q && (ptr_q == 8'hff) |=> (ptr_q == 8'h00)) // RULE_09
    else $error("pointer did not wrap");
  AST_RESET_SEQ: assert property (seq_reset_pair |=> (phase_q == PH_CMD) && !prev7a_q) // RULE_12
    else $error("double reset code did not reset interface");
  AST_IGNORE: assert property (byte_done && (phase_q == PH_CMD) && // RULE_04
      (byte_w != CMD_PTR) && (byte_w != CMD_WRITE) && (byte_w != CMD_READ) |=>
      (phase_q == PH_CMD) && !reg_req.we ##1 $stable(ptr_q))
    else $error("unknown command had an effect");
  AST_MISO_SHIFT: assert property (sclk_fall && !pins_s.cs_n && (bitcnt_q != SRA_BIT_RST) // RULE_05
      |=> (spi_miso == $past(tx_q[6])))
    else $error("output bit not advanced on falling edge");

  // Framing and bit timing
  AST_OE_ON: assert property (cs_fall |=> spi_miso_oe) // RULE_08
    else $error("output not enabled on select");
  AST_DESEL_CMD: assert property (pins_s.cs_n |=> (phase_q == PH_CMD)) // RULE_17
    else $error("command phase not restored on deselect");
  AST_DESEL_CLEAR: assert property (cs_rise |=> (bitcnt_q == SRA_BIT_RST) && !spi_miso_oe) // RULE_17
    else $error("deselect left byte or output active");
  AST_RX_SHIFT: assert property (seq_bit_in |=> // RULE_03
      (rx_q == $past(byte_w)))
    else $error("input bit not taken on rising edge");
  AST_BIT_COUNT: assert property (seq_bit_in |=> // RULE_02
      (bitcnt_q == 3'($past(bitcnt_q) + 3'h1)))
    else $error("bit count did not advance");
  // Idle clock must leave the frame untouched, however long
  AST_HOLD_IDLE: assert property (seq_link_idle |=> // RULE_10
      $stable(bitcnt_q) && $stable(phase_q) && $stable(rx_q))
    else $error("state moved while clock idle");

  // Command decode, data fetch and write strobe
  AST_DECODE_PTR: assert property (seq_cmd_byte ##0 (byte_w == CMD_PTR) |=> // RULE_04
      (phase_q == PH_PTR))
    else $error("set pointer command not decoded");
  AST_DECODE_WRITE: assert property (seq_cmd_byte ##0 (byte_w == CMD_WRITE) |=> // RULE_04
      (phase_q == PH_WRITE))
    else $error("write command not decoded");
  AST_DECODE_READ: assert property (seq_cmd_byte ##0 (byte_w == CMD_READ) |=> // RULE_04
      (phase_q == PH_READ) && inc_q)
    else $error("read command not decoded");
  AST_BYTE_FETCH: assert property (byte_done |=> (tx_q == $past(reg_rdata))) // RULE_14
    else $error("register not fetched at byte end");
  AST_FIRST_LOAD: assert property (cs_fall |=> (tx_q == $past(reg_rdata))) // RULE_05
    else $error("first byte not loaded on select");
  AST_WE_PULSE: assert property (reg_req.we |=> !reg_req.we) // RULE_14
    else $error("write strobe longer than one cycle");

endmodule : sra_port
`default_nettype wire

// File: hdl/sra_pkg.sv
// Shared constants, types and helpers of the SPI register access port
package sra_pkg;

  localparam int SRA_BYTE_W = 8;
  localparam logic [7:0] SRA_RESET_CODE = 8'h7a;
  localparam logic [7:0] SRA_CMD_PTR_DEF = 8'h7d;
  localparam logic [7:0] SRA_CMD_WRITE_DEF = 8'h7e;
  localparam logic [7:0] SRA_CMD_READ_DEF = 8'h7f;
  localparam logic [7:0] SRA_PTR_RST = 8'h00;
  localparam logic [7:0] SRA_BYTE_RST = 8'h00;
  localparam logic [7:0] SRA_TX_RST = 8'hff;
  localparam logic [2:0] SRA_BIT_RST = 3'h0;
  localparam logic [2:0] SRA_LAST_BIT = 3'h7;
  localparam logic [2:0] SRA_PIN_IDLE = 3'h7;

  typedef enum logic [1:0] {
    PH_CMD,
    PH_PTR,
    PH_WRITE,
    PH_READ
  } sra_phase_type;

  // Access request towards the device register space
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
  } sra_reg_req_type;

  // Serial pins, raw or after synchronisation
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } sra_pins_type;

  function automatic logic [7:0] sra_inc8(input logic [7:0] v);
    sra_inc8 = v + 8'h01;
  endfunction : sra_inc8

endpackage : sra_pkg

// File: hdl/sra_sync.sv
// Two-stage synchroniser for the serial pins
`timescale 1ns/10ps
`default_nettype none
module sra_sync
  import sra_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pins in, synchronised copy out
  input wire sra_pins_type pins_i,
  output sra_pins_type pins_o
);

  sra_pins_type meta_q;
  sra_pins_type meta_d;
  sra_pins_type sync_q;
  sra_pins_type sync_d;

  always_comb begin
    meta_d = pins_i;
    sync_d = meta_q;
  end

  // Idle level is all high, so reset does not fake an edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_q <= SRA_PIN_IDLE;
      sync_q <= SRA_PIN_IDLE;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pins_o = sync_q;

endmodule : sra_sync
`default_nettype wire

// File: hdl/sra_edge.sv
// Rise and fall detector on a synchronised level
`timescale 1ns/10ps
`default_nettype none
module sra_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Level in, edge pulses out
  input wire logic level_i,
  output logic rise_o,
  output logic fall_o
);

  logic prev_q;
  logic prev_d;

  always_comb begin
    prev_d = level_i;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise_o = level_i & ~prev_q;
  assign fall_o = ~level_i & prev_q;

endmodule : sra_edge
`default_nettype wire

// File: tb/sra_master.sv
// Behavioural SPI master driving the port from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module sra_master (
  // Serial link
  output var logic sclk,
  output var logic cs_n,
  output var logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  initial begin
    // Clock and data rest high outside frames
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // Select or deselect; only this line addresses the device
  task automatic sel(input logic v);
    #100 cs_n <= v;
    #100;
  endtask : sel

  // Shift nb bits MSB first; sample on the rising edge
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < nb; i++) begin
      #80 sclk <= 1'b0;
      mosi <= tx[7-i];
      #80 acc = {acc[6:0], miso_oe ? miso : ~acc[0]};
      sclk <= 1'b1;
    end
    // Data back to idle level; any trailing read byte is the caller's choice
    #80 mosi <= 1'b1;
    rx = acc;
  endtask : xfer
endmodule : sra_master
`default_nettype wire

// File: tb/sra_port_test.sv
// Self-checking bench for the SPI register access port
`timescale 1ns/10ps
`default_nettype none
module sra_port_test;
  import sra_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  wire logic sclk;
  wire logic cs_n;
  wire logic mosi;
  logic miso;
  logic miso_oe;
  sra_reg_req_type reg_req;
  logic [7:0] reg_rdata;
  logic [7:0] mem [256];
  logic [7:0] rx;
  logic [7:0] last_w;
  int n_fail = 0;
  int n_compared = 0;
  int n_we = 0;
  int n0;

  always #10 clk = ~clk;

  sra_port uut (.clk(clk), .resetn(resetn), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe), .reg_req(reg_req),
    .reg_rdata(reg_rdata));

  sra_master m (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

  // Register space of the core
  assign reg_rdata = mem[reg_req.addr];
  always @(posedge clk) begin
    if (resetn && reg_req.we === 1'b1) begin
      mem[reg_req.addr] <= reg_req.wdata;
      last_w <= reg_req.wdata;
      n_we <= n_we + 1;
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic b(input logic [7:0] v);
    m.xfer(v, 8, rx);
  endtask : b

  task automatic finish_test;
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  // Read across the top of the space
  task automatic t_read_wrap;
    m.sel(1'b0);
    check({7'h00, miso_oe}, 8'h01);
    b(SRA_CMD_PTR_DEF);
    check(rx, 8'h00 ^ 8'h5a);
    b(8'hfe);
    b(SRA_CMD_READ_DEF);
    check(rx, 8'hfe ^ 8'h5a);
    for (int k = 0; k < 3; k++) begin
      b(8'hff);
      check(rx, 8'(8'hfe + k) ^ 8'h5a);
    end
    m.sel(1'b1);
  endtask : t_read_wrap

  // Chained writes, long stall, unknown code
  task automatic t_write;
    m.sel(1'b0);
    b(SRA_CMD_PTR_DEF);
    b(8'h10);
    b(SRA_CMD_WRITE_DEF);
    #5000 b(8'h33);
    b(SRA_CMD_WRITE_DEF);
    check(rx, 8'h10 ^ 8'h5a);
    b(8'h44);
    b(8'h00);
    b(SRA_CMD_READ_DEF);
    b(8'hff);
    check(rx, 8'h12 ^ 8'h5a);
    m.sel(1'b1);
    check(mem[8'h10], 8'h33);
    check(mem[8'h11], 8'h44);
  endtask : t_write

  // Reset pair in mid read
  task automatic t_reset;
    n0 = n_we;
    m.sel(1'b0);
    b(SRA_CMD_PTR_DEF);
    b(8'h20);
    b(SRA_CMD_READ_DEF);
    b(SRA_RESET_CODE);
    b(SRA_RESET_CODE);
    b(SRA_CMD_WRITE_DEF);
    b(8'h66);
    m.sel(1'b1);
    check(8'(n_we - n0), 8'h01);
    check(last_w, 8'h66);
  endtask : t_reset

  // Partial byte, then traffic while deselected
  task automatic t_partial;
    n0 = n_we;
    m.sel(1'b0);
    m.xfer(SRA_CMD_WRITE_DEF, 3, rx);
    m.sel(1'b1);
    check({7'h00, miso_oe}, 8'h00);
    b(SRA_CMD_WRITE_DEF);
    b(8'h55);
    check(8'(n_we - n0), 8'h00);
    m.sel(1'b0);
    b(SRA_CMD_PTR_DEF);
    b(8'h40);
    b(SRA_CMD_WRITE_DEF);
    b(8'h77);
    m.sel(1'b1);
    check(mem[8'h40], 8'h77);
  endtask : t_partial

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    t_read_wrap();
    t_write();
    t_reset();
    t_partial();
    finish_test();
  end

  // Whole run is near 46 us
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end
endmodule : sra_port_test
`default_nettype wire
